// ### testbench/adc_compute_threshold_ctrl_test.sv
// Self-checking bench for the converter compute control block
`timescale 1ns/100ps
module adc_compute_threshold_ctrl_test;
   import adcct_pkg::*;
   logic pclk = 1'b0;
   logic presetn = 1'b0;
   logic psel = 1'b0;
   logic penable = 1'b0;
   logic pwrite = 1'b0;
   logic [ADDR_W-1:0] paddr = '0;
   logic [31:0] pwdata = '0;
   logic [31:0] prdata;
   logic pready;
   logic pslverr;
   adcct_conv_s conv_in = '0;
   adcct_front_s front;
   logic thr_event;
   int error_cnt = 0;
   int samples_checked = 0;
   int ev;
   logic [1:0] lvl;
   logic [1:0] gd;
   logic [33:0] exp_q[$];
   logic [31:0] seed = 32'hED18;
   logic [31:0] d;
   logic [11:0] r1;
   logic [11:0] r2;
   logic [15:0] sp;
   logic [7:0] thr_tbl = 8'hAC;

   adcct_core i_adcct_core (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
      .pslverr(pslverr), .conv_in(conv_in), .front(front), .thr_event(thr_event));

   always #2.5 pclk = ~pclk;

   function automatic logic [31:0] xs(input logic [31:0] s);
      s = s ^ (s << 13);
      s = s ^ (s >> 17);
      s = s ^ (s << 5);
      return s;
   endfunction

   task automatic final_report();
      $display("checks %0d mismatches %0d", samples_checked, error_cnt);
      if (error_cnt == 0 && samples_checked > 0) begin
         $display("bench passed");
      end else begin
         $display("bench failed");
      end
      $finish;
   endtask

   task automatic fail(input string msg);
      error_cnt++;
      $display("CHECK FAILED at %0t: %s", $time, msg);
   endtask

   task automatic check(input logic ok, input string msg);
      samples_checked++;
      if (ok !== 1'b1) begin
         fail(msg);
      end
   endtask

   // Entry: {compare data, expected error, expected data}
   task automatic apb(input logic wr, input logic [9:0] idx, input logic [31:0] wd,
                      input logic [33:0] e, output logic [31:0] rd);
      int i;
      @(posedge pclk);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= wr;
      paddr <= {idx, 2'b00};
      pwdata <= wd;
      exp_q.push_back(e);
      @(posedge pclk);
      penable <= 1'b1;
      for (i = 0; i < 20; i++) begin
         @(posedge pclk);
         if (pready === 1'b1) break;
      end
      rd = prdata;
      psel <= 1'b0;
      penable <= 1'b0;
      if (i == 20) begin
         fail("bus wait ran out");
         final_report();
      end
   endtask

   task automatic wr(input logic [9:0] idx, input logic [31:0] wd);
      apb(1'b1, idx, wd, 34'h0, d);
   endtask

   task automatic rd(input logic [9:0] idx, input logic [31:0] e);
      apb(1'b0, idx, 32'h0, {2'b10, e}, d);
   endtask

   always @(posedge pclk) begin
      if (psel && penable && pready === 1'b1) begin
         logic [33:0] e;
         e = exp_q.pop_front();
         samples_checked++;
         if (pslverr !== e[32] || (e[33] && prdata !== e[31:0])) begin
            fail("bus answer differs");
         end
      end
   end

   // Sample outputs mid-cycle, answer conversions right after the edge
   task automatic conv(input logic [31:0] ctl, input int n, input logic [11:0] a,
                       input logic [11:0] b);
      int got;
      int i;
      logic pend;
      got = 0;
      ev = 0;
      wr(IDX_CONV_CTRL, ctl);
      for (i = 0; i < 200 && got < n; i++) begin
         @(negedge pclk);
         if (thr_event === 1'b1) ev++;
         if (front.precharge_en === 1'b1) begin
            lvl[front.second] = front.precharge_level;
            gd[front.second] = front.guard_level;
         end
         pend = front.sample_req === 1'b1 && conv_in.done !== 1'b1;
         @(posedge pclk);
         if (pend) begin
            conv_in <= '{done: 1'b1, data: (got == 0) ? a : b};
            got++;
         end else begin
            conv_in.done <= 1'b0;
         end
      end
      repeat (6) begin
         @(negedge pclk);
         if (thr_event === 1'b1) ev++;
         @(posedge pclk);
         conv_in.done <= 1'b0;
      end
      if (got < n) begin
         fail("conversion request never came");
         final_report();
      end
   endtask

   initial begin
      repeat (16) @(posedge pclk);
      presetn <= 1'b1;
      rd(IDX_PRE_CTRL, 32'h0);
      rd(IDX_COMP_CTRL, 32'h0);
      rd(IDX_DEV_CTRL, 32'h0);
      rd(IDX_STATUS, 32'h0);
      seed = xs(seed);
      wr(IDX_PRE_CTRL, seed);
      rd(IDX_PRE_CTRL, {24'h0, seed[7:0] & PRE_CTRL_MASK});
      apb(1'b0, 10'h3FF, 32'h0, {2'b11, 32'h0}, d);
      $display("registers done");
      // Single conversion with precharge, result against setpoint
      seed = xs(seed);
      r1 = seed[11:0];
      sp = seed[31:16];
      wr(IDX_PRE_CTRL, 32'hA0);
      wr(IDX_COMP_CTRL, 32'h0);
      wr(IDX_DEV_CTRL, 32'h17);
      wr(IDX_SETPOINT, {16'h0, sp});
      conv(32'h0201, 1, r1, 12'h0);
      check(lvl[0] === 1'b1 && gd[0] === 1'b1, "first precharge levels");
      check(ev == 1, "always mode event");
      rd(IDX_DEVIATION, {16'h0, {4'h0, r1} - sp});
      rd(IDX_CONV_CTRL, 32'h0200);
      $display("single done");
      // Double sample, inverted second precharge
      seed = xs(seed);
      r1 = seed[11:0];
      r2 = seed[27:16];
      wr(IDX_PRE_CTRL, 32'h41);
      wr(IDX_DEV_CTRL, 32'h07);
      conv(32'h0201, 2, r1, r2);
      check(lvl === 2'b10 && gd === 2'b10, "second stage levels inverted");
      rd(IDX_PREV, {20'h0, r1});
      rd(IDX_DEVIATION, {16'h0, {4'h0, r2} - {4'h0, r1}});
      $display("double done");
      // Every threshold mode against a deviation between the thresholds
      wr(IDX_PRE_CTRL, 32'h0);
      wr(IDX_SETPOINT, 32'h0);
      wr(IDX_LOWER, 32'h0064);
      wr(IDX_UPPER, 32'h00C8);
      for (int m = 0; m < 8; m++) begin
         wr(IDX_DEV_CTRL, 32'h10 | m);
         conv(32'h0001, 1, 12'h096, 12'h0);
         check(ev == int'(thr_tbl[m]), "threshold mode event");
      end
      $display("threshold done");
      // Auto repeat with and without stop on threshold
      for (int s = 0; s < 2; s++) begin
         wr(IDX_DEV_CTRL, 32'h17 | (s << 3));
         conv(32'h0003, 1, 12'h123, 12'h0);
         rd(IDX_CONV_CTRL, (s == 1) ? 32'h2 : 32'h3);
         wr(IDX_CONV_CTRL, 32'h0);
      end
      $display("repeat done");
      // Accumulate with shift one, clear, then average and low-pass
      wr(IDX_REPEAT, 32'h2);
      wr(IDX_COMP_CTRL, 32'h11);
      wr(IDX_DEV_CTRL, 32'h0);
      conv(32'h0001, 1, 12'hABC, 12'h0);
      rd(IDX_SUM, 32'h0ABC);
      rd(IDX_FILTER, 32'h055E);
      rd(IDX_COUNT, 32'h1);
      wr(IDX_COMP_CTRL, 32'h19);
      for (int i = 0; i <= 50; i++) begin
         apb(1'b0, IDX_COMP_CTRL, 32'h0, 34'h0, d);
         if (d[SUM_CLEAR_CMD_BIT] === 1'b0) break;
         if (i == 50) begin
            fail("sum clear never finished");
            final_report();
         end
      end
      rd(IDX_SUM, 32'h0);
      rd(IDX_COUNT, 32'h0);
      wr(IDX_COMP_CTRL, 32'h12);
      conv(32'h0001, 1, 12'h100, 12'h0);
      conv(32'h0001, 1, 12'h200, 12'h0);
      rd(IDX_FILTER, 32'h0180);
      rd(IDX_SUM, 32'h0);
      wr(IDX_COMP_CTRL, 32'h94);
      conv(32'h0001, 1, 12'h100, 12'h0);
      rd(IDX_PREV, 32'h0180);
      rd(IDX_FILTER, 32'h0080);
      $display("accumulate done");
      final_report();
   end
endmodule

// ### verilog/adcct_core.sv
// Converter compute control: registers, conversion sequencer, accumulator
//
// Implementation choice: the APB slave port.
`timescale 1ns/100ps
module adcct_core (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [adcct_pkg::ADDR_W-1:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   input wire adcct_pkg::adcct_conv_s conv_in,
   output adcct_pkg::adcct_front_s front,
   output logic thr_event
);
   import adcct_pkg::*;

   typedef struct packed {
      adcct_state_e st;
      logic [7:0] pre_cnt;
      logic [7:0] pre_ctrl;
      logic [7:0] comp_ctrl;
      logic [7:0] dev_ctrl;
      logic go;
      logic auto_rep;
      logic [7:0] pre_time;
      logic [CNT_W-1:0] repeat_count;
      logic [VAL_W-1:0] setpoint;
      logic [VAL_W-1:0] upper;
      logic [VAL_W-1:0] lower;
      logic [RES_W-1:0] result;
      logic [VAL_W-1:0] prev;
      logic [VAL_W-1:0] filter;
      logic [VAL_W-1:0] deviation;
      logic [SUM_W-1:0] sum;
      logic [CNT_W-1:0] count;
      logic ov;
      logic above;
      logic below;
      logic math;
      logic [2:0] sum_clear_cmd_cnt;
      adcct_front_s front;
      logic thr_event;
      logic [31:0] prdata;
      logic pready;
      logic pslverr;
   } adcct_regs_s;

   adcct_regs_s r_reg, r_next;
   logic [VAL_W-1:0] dev_val;
   logic dev_ovf, dev_above, dev_below, dev_met;

   function automatic logic [2:0] stage_code(input adcct_state_e s);
      case (s)
         ST_PRE1: stage_code = STAGE_PRE1;
         ST_CONV1: stage_code = STAGE_CONV1;
         ST_PRE2: stage_code = STAGE_PRE2;
         ST_CONV2: stage_code = STAGE_CONV2;
         default: stage_code = STAGE_IDLE;
      endcase
   endfunction

   function automatic logic [VAL_W-1:0] shifted(input logic [SUM_W-1:0] v,
                                                 input logic [2:0] n);
      logic [SUM_W-1:0] t;
      t = v >> n;
      shifted = t[VAL_W-1:0];
   endfunction

   adcct_deviation i_adcct_deviation (
      .formula(r_reg.dev_ctrl[DEVIATION_FORMULA_LSB +: 3]),
      .thr_mode(r_reg.dev_ctrl[TMD_LSB +: 3]),
      .double_en(r_reg.pre_ctrl[DOUBLE_SAMPLE_EN_BIT]),
      .result(r_reg.result),
      .prev(r_reg.prev),
      .filter(r_reg.filter),
      .setpoint(r_reg.setpoint),
      .lower(r_reg.lower),
      .upper(r_reg.upper),
      .deviation(dev_val),
      .overflow(dev_ovf),
      .above_upper(dev_above),
      .below_lower(dev_below),
      .thr_met(dev_met)
   );

   logic wr, setup;
   logic [9:0] idx;
   logic double_sample_en, history_source_sel, inv;
   logic [2:0] shift_field, mode;
   logic [SUM_W:0] acc;
   logic [SUM_W-1:0] lpf;
   logic [CNT_W-1:0] cnt_new;
   logic go_set;

   always_comb begin
      r_next = r_reg;
      setup = psel && !penable;
      wr = psel && penable && r_reg.pready && pwrite;
      idx = paddr[ADDR_W-1:2];
      double_sample_en = r_reg.pre_ctrl[DOUBLE_SAMPLE_EN_BIT];
      history_source_sel = r_reg.comp_ctrl[HISTORY_SOURCE_SEL_BIT];
      shift_field = r_reg.comp_ctrl[CRS_LSB +: 3];
      mode = r_reg.comp_ctrl[MODE_LSB +: 3];
      acc = {1'b0, r_reg.sum} + {{(SUM_W+1-RES_W){1'b0}}, r_reg.result};
      lpf = r_reg.sum - (r_reg.sum >> shift_field) + {{(SUM_W-RES_W){1'b0}}, r_reg.result};
      cnt_new = r_reg.count + 8'h01;
      go_set = wr && (idx == IDX_CONV_CTRL) && pwdata[GO_BIT];
      r_next.thr_event = 1'b0;

      // Bus slave: read data latched in setup, answer on first access cycle
      r_next.pready = setup;
      if (setup) begin
         r_next.pslverr = 1'b0;
         case (idx)
            IDX_PRE_CTRL: r_next.prdata = {24'h000000, r_reg.pre_ctrl};
            IDX_COMP_CTRL: r_next.prdata = {24'h000000, r_reg.comp_ctrl};
            IDX_DEV_CTRL: r_next.prdata = {24'h000000, r_reg.dev_ctrl};
            IDX_STATUS: r_next.prdata = {24'h000000, r_reg.ov, r_reg.above,
                                          r_reg.below, r_reg.math, 1'b0,
                                          stage_code(r_reg.st)};
            IDX_CONV_CTRL: r_next.prdata = {16'h0000, r_reg.pre_time, 6'h00,
                                             r_reg.auto_rep, r_reg.go};
            IDX_REPEAT: r_next.prdata = {24'h000000, r_reg.repeat_count};
            IDX_SETPOINT: r_next.prdata = {16'h0000, r_reg.setpoint};
            IDX_UPPER: r_next.prdata = {16'h0000, r_reg.upper};
            IDX_LOWER: r_next.prdata = {16'h0000, r_reg.lower};
            IDX_RESULT: r_next.prdata = {20'h00000, r_reg.result};
            IDX_PREV: r_next.prdata = {16'h0000, r_reg.prev};
            IDX_FILTER: r_next.prdata = {16'h0000, r_reg.filter};
            IDX_DEVIATION: r_next.prdata = {16'h0000, r_reg.deviation};
            IDX_SUM: r_next.prdata = {8'h00, r_reg.sum};
            IDX_COUNT: r_next.prdata = {24'h000000, r_reg.count};
            default: begin
               r_next.prdata = 32'h00000000;
               r_next.pslverr = 1'b1;
            end
         endcase
      end
      if (wr) begin
         case (idx)
            IDX_PRE_CTRL: r_next.pre_ctrl = pwdata[7:0] & PRE_CTRL_MASK;
            IDX_COMP_CTRL: r_next.comp_ctrl = pwdata[7:0];
            IDX_DEV_CTRL: r_next.dev_ctrl = pwdata[7:0] & DEV_CTRL_MASK;
            IDX_CONV_CTRL: begin
               r_next.go = pwdata[GO_BIT]; // RL22
               r_next.auto_rep = pwdata[AUTO_BIT];
               r_next.pre_time = pwdata[PRE_TIME_LSB +: 8];
            end
            IDX_REPEAT: r_next.repeat_count = pwdata[CNT_W-1:0];
            IDX_SETPOINT: r_next.setpoint = pwdata[VAL_W-1:0];
            IDX_UPPER: r_next.upper = pwdata[VAL_W-1:0];
            IDX_LOWER: r_next.lower = pwdata[VAL_W-1:0];
            default: ;
         endcase
      end

      // Sequencer
      case (r_reg.st)
         ST_IDLE: begin
            r_next.pre_cnt = 8'h00;
            if (r_reg.go) begin // RL22
               r_next.math = 1'b0;
               if (r_reg.pre_time != 8'h00) begin
                  r_next.st = ST_PRE1;
               end else begin
                  r_next.st = ST_CONV1;
                  r_next.prev = history_source_sel ? r_reg.filter : {4'h0, r_reg.result}; // RL5
               end
            end
         end
         ST_PRE1, ST_PRE2: begin
            r_next.pre_cnt = r_reg.pre_cnt + 8'h01;
            // Compare by size so a shorter time written mid-stage cannot wrap the count
            if (r_next.pre_cnt >= r_reg.pre_time) begin
               r_next.st = (r_reg.st == ST_PRE1) ? ST_CONV1 : ST_CONV2;
               r_next.prev = history_source_sel ? r_reg.filter : {4'h0, r_reg.result}; // RL5
            end
         end
         ST_CONV1, ST_CONV2: begin
            r_next.pre_cnt = 8'h00;
            if (conv_in.done) begin
               r_next.result = conv_in.data;
               if (r_reg.st == ST_CONV1 && double_sample_en) begin // RL4
                  if (r_reg.pre_time != 8'h00) begin
                     r_next.st = ST_PRE2;
                  end else begin
                     r_next.st = ST_CONV2;
                     r_next.prev = history_source_sel ? r_reg.filter : {4'h0, conv_in.data}; // RL5
                  end
               end else begin
                  r_next.st = ST_DEVIATION_FORMULA; // RL4
               end
            end
         end
         ST_DEVIATION_FORMULA: begin
            r_next.st = ST_IDLE;
            r_next.math = 1'b1;
            r_next.deviation = dev_val;
            r_next.above = dev_above; // RL21
            r_next.below = dev_below; // RL21
            r_next.thr_event = dev_met; // RL20
            r_next.ov = r_reg.ov || dev_ovf;
            case (mode) // RL12
               MODE_ACCUM: begin
                  r_next.sum = acc[SUM_W-1:0];
                  r_next.ov = r_reg.ov || dev_ovf || acc[SUM_W];
                  r_next.count = cnt_new;
                  r_next.filter = shifted(acc[SUM_W-1:0], shift_field); // RL7
               end
               MODE_AVG, MODE_BURST: begin
                  r_next.sum = acc[SUM_W-1:0];
                  r_next.ov = r_reg.ov || dev_ovf || acc[SUM_W];
                  r_next.count = cnt_new;
                  if (cnt_new >= r_reg.repeat_count) begin
                     r_next.filter = shifted(acc[SUM_W-1:0], shift_field); // RL7
                     r_next.sum = {SUM_W{1'b0}};
                     r_next.count = {CNT_W{1'b0}};
                  end
               end
               MODE_LPF: begin
                  // Sum holds filter scaled by 2^shift, so gain stays one
                  r_next.sum = lpf; // RL6
                  r_next.count = cnt_new;
                  r_next.filter = shifted(lpf, shift_field); // RL6
               end
               default: r_next.filter = {4'h0, r_reg.result}; // RL8
            endcase
            if (!r_reg.auto_rep) begin
               r_next.go = go_set; // RL22
            end else if (r_reg.dev_ctrl[SOI_BIT] && dev_met) begin // RL19
               r_next.go = go_set; // RL18
            end
         end
         default: r_next.st = ST_IDLE;
      endcase
      // Software abort before ST_DEVIATION_FORMULA drops the cycle without any calculation
      if (!r_next.go && r_reg.st != ST_DEVIATION_FORMULA) begin
         r_next.st = ST_IDLE;
      end

      // Sum clear: software set wins over the hardware completion clear
      if (r_reg.comp_ctrl[SUM_CLEAR_CMD_BIT]) begin
         r_next.sum = {SUM_W{1'b0}}; // RL10
         r_next.count = {CNT_W{1'b0}};
         r_next.ov = 1'b0;
         r_next.sum_clear_cmd_cnt = r_reg.sum_clear_cmd_cnt + 3'h1;
         if (r_reg.sum_clear_cmd_cnt == SUM_CLEAR_CMD_CYCLES - 3'h1) begin
            r_next.comp_ctrl[SUM_CLEAR_CMD_BIT] = 1'b0; // RL10
            r_next.sum_clear_cmd_cnt = 3'h0;
         end
      end
      if (wr && idx == IDX_COMP_CTRL && pwdata[SUM_CLEAR_CMD_BIT]) begin
         r_next.comp_ctrl[SUM_CLEAR_CMD_BIT] = 1'b1;
         r_next.sum_clear_cmd_cnt = 3'h0;
      end

      // Front-end levels; inverted only on the second of a double sample
      inv = double_sample_en && r_reg.pre_ctrl[INVERTED_PRECHARGE_EN_BIT] &&
            (r_next.st == ST_PRE2 || r_next.st == ST_CONV2); // RL2
      r_next.front.second = (r_next.st == ST_PRE2 || r_next.st == ST_CONV2);
      r_next.front.precharge_en = (r_next.st == ST_PRE1 || r_next.st == ST_PRE2);
      r_next.front.precharge_level = r_reg.pre_ctrl[PRECHARGE_POLARITY_BIT] ^ inv; // RL1
      r_next.front.guard_level = r_reg.pre_ctrl[GUARD_POLARITY_BIT] ^ inv; // RL3
      r_next.front.sample_req = (r_next.st == ST_CONV1 || r_next.st == ST_CONV2);
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         r_reg <= '0;
      end else begin
         r_reg <= r_next;
      end
   end

   assign prdata = r_reg.prdata;
   assign pready = r_reg.pready;
   assign pslverr = r_reg.pslverr;
   assign front = r_reg.front;
   assign thr_event = r_reg.thr_event;

   default clocking cb @(posedge pclk); endclocking
   default disable iff (!presetn);

   property p_prev_source;
      $changed(r_reg.st) && (r_reg.st == ST_CONV1) && !$past(conv_in.done) |->
         r_reg.prev == ($past(history_source_sel) ? $past(r_reg.filter) : {4'h0, $past(r_reg.result)});
   endproperty
   a_prev_source: assert property (p_prev_source) else $error("earlier sample source wrong"); // RL5

   property p_single;
      (r_reg.st == ST_CONV1) && conv_in.done && !double_sample_en && r_next.go |=> r_reg.st == ST_DEVIATION_FORMULA;
   endproperty
   a_single: assert property (p_single) else $error("single sample not one conversion"); // RL4

   property p_double;
      (r_reg.st == ST_CONV1) && conv_in.done && double_sample_en && r_next.go |=>
         (r_reg.st == ST_PRE2 || r_reg.st == ST_CONV2) && r_reg.front.second;
   endproperty
   a_double: assert property (p_double) else $error("double sample skipped second"); // RL4

   property p_pre_level;
      r_reg.front.precharge_en && !r_reg.front.second |->
         r_reg.front.precharge_level == $past(r_reg.pre_ctrl[PRECHARGE_POLARITY_BIT]) &&
         r_reg.front.guard_level == $past(r_reg.pre_ctrl[GUARD_POLARITY_BIT]);
   endproperty
   a_pre_level: assert property (p_pre_level) else $error("first precharge level wrong"); // RL1

   property p_invert;
      r_reg.front.precharge_en && r_reg.front.second && $past(double_sample_en) &&
         $past(r_reg.pre_ctrl[INVERTED_PRECHARGE_EN_BIT]) |->
         r_reg.front.precharge_level != $past(r_reg.pre_ctrl[PRECHARGE_POLARITY_BIT]) &&
         r_reg.front.guard_level != $past(r_reg.pre_ctrl[GUARD_POLARITY_BIT]);
   endproperty
   a_invert: assert property (p_invert) else $error("second precharge not inverted"); // RL2

   property p_stop_on_thr;
      (r_reg.st == ST_DEVIATION_FORMULA) && r_reg.auto_rep && r_reg.dev_ctrl[SOI_BIT] && dev_met &&
         !go_set |=> !r_reg.go && r_reg.thr_event;
   endproperty
   a_stop_on_thr: assert property (p_stop_on_thr) else $error("trigger not stopped"); // RL18

   property p_retrigger;
      (r_reg.st == ST_DEVIATION_FORMULA) && r_reg.auto_rep && !r_reg.dev_ctrl[SOI_BIT] &&
         !(wr && idx == IDX_CONV_CTRL) |=>
         r_reg.go ##1 (r_reg.st != ST_IDLE || !r_reg.go);
   endproperty
   a_retrigger: assert property (p_retrigger) else $error("auto repeat stopped"); // RL19

   property p_basic;
      (r_reg.st == ST_DEVIATION_FORMULA) && (mode == MODE_BASIC) && !r_reg.comp_ctrl[SUM_CLEAR_CMD_BIT] |=>
         r_reg.filter == {4'h0, $past(r_reg.result)} && $stable(r_reg.sum);
   endproperty
   a_basic: assert property (p_basic) else $error("basic mode used shift"); // RL8

   sequence s_clear_started;
      $rose(r_reg.comp_ctrl[SUM_CLEAR_CMD_BIT]);
   endsequence
   property p_clear;
      s_clear_started |=> (r_reg.sum == '0 && r_reg.count == '0 && !r_reg.ov) ##[1:8]
         !r_reg.comp_ctrl[SUM_CLEAR_CMD_BIT];
   endproperty
   a_clear: assert property (p_clear) else $error("sum clear never completed"); // RL10
endmodule

// ### verilog/adcct_deviation.sv
// Deviation arithmetic and threshold comparison for the compute block
`timescale 1ns/100ps
module adcct_deviation (
   input wire logic [2:0] formula,
   input wire logic [2:0] thr_mode,
   input wire logic double_en,
   input wire logic [adcct_pkg::RES_W-1:0] result,
   input wire logic [adcct_pkg::VAL_W-1:0] prev,
   input wire logic [adcct_pkg::VAL_W-1:0] filter,
   input wire logic [adcct_pkg::VAL_W-1:0] setpoint,
   input wire logic [adcct_pkg::VAL_W-1:0] lower,
   input wire logic [adcct_pkg::VAL_W-1:0] upper,
   output logic [adcct_pkg::VAL_W-1:0] deviation,
   output logic overflow,
   output logic above_upper,
   output logic below_lower,
   output logic thr_met
);
   import adcct_pkg::*;
   localparam int EXT_W = VAL_W + 2;
   logic signed [EXT_W-1:0] r, p, f, s, d;
   logic above_lower;

   always_comb begin
      r = $signed({6'h00, result});
      p = EXT_W'($signed(prev));
      f = EXT_W'($signed(filter));
      s = EXT_W'($signed(setpoint));
      case (formula)
         DEVIATION_FORMULA_PREV: d = r - p; // RL13
         DEVIATION_FORMULA_SETPT: d = double_en ? (r - p) - s : r - s; // RL14
         DEVIATION_FORMULA_FILT: d = double_en ? (r - p) - f : r - f; // RL15
         DEVIATION_FORMULA_PREV_FILT: d = p - f; // RL16
         DEVIATION_FORMULA_FILT_SETPT: d = f - s; // RL17
         default: d = 18'h00000; // RL17
      endcase
      deviation = d[VAL_W-1:0];
      overflow = (d[EXT_W-1:VAL_W-1] != 3'h0) && (d[EXT_W-1:VAL_W-1] != 3'h7);
      above_upper = $signed(deviation) > $signed(upper); // RL21
      below_lower = $signed(deviation) < $signed(lower); // RL21
      above_lower = $signed(deviation) > $signed(lower);
      case (thr_mode) // RL20
         3'h0: thr_met = 1'b0;
         3'h1: thr_met = below_lower;
         3'h2: thr_met = !below_lower;
         3'h3: thr_met = above_lower && ($signed(deviation) < $signed(upper));
         3'h4: thr_met = below_lower || above_upper;
         3'h5: thr_met = !above_upper;
         3'h6: thr_met = above_upper;
         default: thr_met = 1'b1;
      endcase
   end
endmodule

// ### verilog/adcct_pkg.sv
// Constants, register map and carrier types for the converter compute block
// Notes on behaviour
// [RL1] Precharge level follows polarity bit when precharging
// [RL2] Inverted precharge flips second conversion's levels
// [RL3] Guard outputs start at guard polarity level
// [RL4] Double sampling gives two conversions per trigger
// [RL5] Earlier sample loads filter or result
// [RL6] Low-pass time constant is two to shift
// [RL7] Accumulating modes right-shift sum by shift
// [RL8] Basic mode ignores the shift field
// [RL9] Software never programs shift field all ones
// [RL10] Sum clear command clears sum, flag, count
// [RL11] Software sets repeat count to power two
// [RL12] Compute mode selects basic to low-pass
// [RL13] Formula 000: result minus earlier sample
// [RL14] Formula 001: result minus setpoint variants
// [RL15] Formula 010: result minus filter variants
// [RL16] Formula 100: earlier sample minus filter
// [RL17] Formula 101: filter minus setpoint; others reserved
// [RL18] Stop-on-threshold clears trigger when condition met
// [RL19] In auto repeat without stop-on-threshold trigger keeps retriggering
// [RL20] Threshold mode selects interrupt comparison
// [RL21] Status shows above-upper and below-lower flags
// [RL22] Trigger bit starts a conversion cycle
package adcct_pkg;
   localparam int ADDR_W = 12;
   localparam int RES_W = 12;
   localparam int VAL_W = 16;
   localparam int SUM_W = 24;
   localparam int CNT_W = 8;
   // Register indices; byte address is four times the index
   localparam logic [9:0] IDX_PRE_CTRL = 10'h112;
   localparam logic [9:0] IDX_COMP_CTRL = 10'h113;
   localparam logic [9:0] IDX_DEV_CTRL = 10'h114;
   localparam logic [9:0] IDX_STATUS = 10'h115;
   localparam logic [9:0] IDX_CONV_CTRL = 10'h120;
   localparam logic [9:0] IDX_REPEAT = 10'h121;
   localparam logic [9:0] IDX_SETPOINT = 10'h122;
   localparam logic [9:0] IDX_UPPER = 10'h123;
   localparam logic [9:0] IDX_LOWER = 10'h124;
   localparam logic [9:0] IDX_RESULT = 10'h125;
   localparam logic [9:0] IDX_PREV = 10'h126;
   localparam logic [9:0] IDX_FILTER = 10'h127;
   localparam logic [9:0] IDX_DEVIATION = 10'h128;
   localparam logic [9:0] IDX_SUM = 10'h129;
   localparam logic [9:0] IDX_COUNT = 10'h12A;
   // Field positions
   localparam int PRECHARGE_POLARITY_BIT = 7;
   localparam int INVERTED_PRECHARGE_EN_BIT = 6;
   localparam int GUARD_POLARITY_BIT = 5;
   localparam int DOUBLE_SAMPLE_EN_BIT = 0;
   localparam int HISTORY_SOURCE_SEL_BIT = 7;
   localparam int CRS_LSB = 4;
   localparam int SUM_CLEAR_CMD_BIT = 3;
   localparam int MODE_LSB = 0;
   localparam int DEVIATION_FORMULA_LSB = 4;
   localparam int SOI_BIT = 3;
   localparam int TMD_LSB = 0;
   localparam int GO_BIT = 0;
   localparam int AUTO_BIT = 1;
   localparam int PRE_TIME_LSB = 8;
   localparam int ST_OV_BIT = 7;
   localparam int ST_UP_BIT = 6;
   localparam int ST_LO_BIT = 5;
   localparam int ST_MATH_BIT = 4;
   localparam logic [7:0] PRE_CTRL_MASK = 8'hE1;
   localparam logic [7:0] DEV_CTRL_MASK = 8'h7F;
   localparam logic [7:0] CTRL_RESET = 8'h00;
   // Clear command stays busy this long, as the sum path is multi-cycle in silicon
   localparam logic [2:0] SUM_CLEAR_CMD_CYCLES = 3'h4;
   localparam logic [2:0] MODE_BASIC = 3'h0;
   localparam logic [2:0] MODE_ACCUM = 3'h1;
   localparam logic [2:0] MODE_AVG = 3'h2;
   localparam logic [2:0] MODE_BURST = 3'h3;
   localparam logic [2:0] MODE_LPF = 3'h4;
   localparam logic [2:0] DEVIATION_FORMULA_PREV = 3'h0;
   localparam logic [2:0] DEVIATION_FORMULA_SETPT = 3'h1;
   localparam logic [2:0] DEVIATION_FORMULA_FILT = 3'h2;
   localparam logic [2:0] DEVIATION_FORMULA_PREV_FILT = 3'h4;
   localparam logic [2:0] DEVIATION_FORMULA_FILT_SETPT = 3'h5;
   localparam logic [2:0] STAGE_IDLE = 3'h0;
   localparam logic [2:0] STAGE_PRE1 = 3'h1;
   localparam logic [2:0] STAGE_CONV1 = 3'h3;
   localparam logic [2:0] STAGE_PRE2 = 3'h5;
   localparam logic [2:0] STAGE_CONV2 = 3'h7;

   typedef enum logic [2:0] {
      ST_IDLE = 3'h0, ST_PRE1 = 3'h1, ST_CONV1 = 3'h3,
      ST_PRE2 = 3'h2, ST_CONV2 = 3'h6, ST_DEVIATION_FORMULA = 3'h7
   } adcct_state_e;

   typedef struct packed {
      logic precharge_en;
      logic precharge_level;
      logic guard_level;
      logic sample_req;
      logic second;
   } adcct_front_s;

   typedef struct packed {
      logic done;
      logic [RES_W-1:0] data;
   } adcct_conv_s;
endpackage
